// File: include/rsfs_pkg.sv
// Constants, state codes and helpers for the regulator start-up and fault sequencer.
// Assumes one 125 MHz core clock.
package rsfs_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ   = 125;
  localparam int LATCH_US  = 50;                 // Two-phase over-current persistence time
  localparam int LATCH_CYC = LATCH_US * CLK_MHZ; // Cycles, exact at 125 MHz
  localparam int STEP_CYC  = 125;                // Slow voltage step period in cycles
  localparam int SENSE_CYC = 64;                 // Configuration sensing window in cycles
  localparam int CNT_W     = 16;

  // ----------------------------------------
  // Structure
  // ----------------------------------------
  localparam int NRAIL     = 3;
  localparam int NPH       = 4;
  localparam int REF_W     = 8;
  localparam int MAIN_RAIL = 0;
  // Rail owning each phase: phases 0,1 main rail, 2 rail 1, 3 rail 2
  localparam logic [2*NPH-1:0] PH_RAIL = 8'h90;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [7:0] {
    S_SENSE = 8'h01,
    S_WAIT  = 8'h02,
    S_MID   = 8'h04,
    S_HSHK  = 8'h08,
    S_RAMP  = 8'h10,
    S_RUN   = 8'h20,
    S_OVP   = 8'h40,
    S_IDLE  = 8'h80
  } rsfs_state_t;

  typedef enum logic [1:0] {
    PWM_OPEN = 2'h0,
    PWM_MID  = 2'h1,
    PWM_LOW  = 2'h2,
    PWM_HIGH = 2'h3
  } rsfs_pwm_t;

  function automatic logic [1:0] ph_rail(input int ph);
    ph_rail = PH_RAIL[2*ph +: 2];
  endfunction

endpackage

// File: rtl/rsfs_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent slow level; no bus coherence.
module rsfs_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ----------------------------------------
  // Two flops; only the second is read
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// File: rtl/rsfs_seq.sv
// Start-up sequencing and latched fault protection of a three-rail buck controller.
// Assumes analog comparators and pins are asynchronous; modulator requests and codes are
// on core_clk. Power cycling is arst_n; an enable toggle clears latched faults.
// Operation
// - Soft start ramps reference from zero to target at the slow step rate
// - At power-up PWM stays open with test current while sensing configuration
// - After sensing and when enabled, PWM outputs go to mid level
// - Driver enable handshake asserted only after PWM is at mid level
// - During ramp each phase holds mid until its first pulse
// - A disabled rail returns its PWM to mid level
// - Handshake held low defers start-up; soft start then begins at mid
// - Single-phase current limit trip latches that rail off at once
// - Two-phase current limit trip latches off after 50 us persistence
// - Two-phase current at 150 percent limit latches off immediately
// - Over-current shutdown holds until power cycle or enable toggle
// - Output 300 mV under reference minus droop drops ready flag
// - Over-voltage drops ready flag and ramps reference down to zero
// - Over-voltage turns all high sides off and low sides on
// - Over-voltage state holds until power cycle or enable toggle
// - During start-up a fixed 2.0 V over-voltage threshold is used
// - Each upward reference step after a voltage change emits one pulse
// - Single-phase rail with sense input high is disabled; main rail never
module rsfs_seq
  import rsfs_pkg::*;
#(
  parameter int LATCH_CYCLES = rsfs_pkg::LATCH_CYC,
  parameter int STEP_CYCLES  = rsfs_pkg::STEP_CYC,
  parameter int SENSE_CYCLES = rsfs_pkg::SENSE_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  input  wire logic                       enable_pin,
  input  wire logic                       driver_enable_handshake_i,
  output logic                            driver_enable_handshake_o,
  output logic                            driver_enable_handshake_oe,
  input  wire logic [1:0]                 current_sense_positive_high,
  input  wire logic [rsfs_pkg::NRAIL-1:0] current_limit_sense_trip,
  input  wire logic                       current_limit_sense_trip150,
  input  wire logic [rsfs_pkg::NRAIL-1:0] undervoltage_trip,
  input  wire logic [rsfs_pkg::NRAIL-1:0] overvoltage_trip_rel,
  input  wire logic [rsfs_pkg::NRAIL-1:0] overvoltage_trip_fixed,
  input  wire logic [rsfs_pkg::NPH-1:0]   pwm_request,
  input  wire logic [rsfs_pkg::REF_W-1:0] boot_code,
  input  wire logic [rsfs_pkg::REF_W-1:0] dynamic_voltage_change_code,
  input  wire logic                       dynamic_voltage_change_load,
  output logic [2*rsfs_pkg::NPH-1:0]      pwm_code,
  output logic                            test_current_en,
  output logic [rsfs_pkg::REF_W-1:0]      ref_code,
  output logic                            negative_sense_input_pulse,
  output logic                            regulator_ready_flag,
  output logic [rsfs_pkg::NRAIL-1:0]      rail_fault,
  output logic [rsfs_pkg::NRAIL-1:0]      rail_disabled
);

  import rsfs_pkg::*;

  localparam logic [CNT_W-1:0] LATCH_LAST = CNT_W'(LATCH_CYCLES - 1);
  localparam logic [CNT_W-1:0] STEP_LAST  = CNT_W'(STEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] SENSE_LAST = CNT_W'(SENSE_CYCLES - 1);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic             en_s, hs_s, i150_s;
  logic [1:0]       csp_s;
  logic [NRAIL-1:0] current_limit_sense_s, uv_s, ovr_s, ovf_s;

  rsfs_sync #(.W(5 + 4*NRAIL)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_i  ({enable_pin, driver_enable_handshake_i, current_sense_positive_high,
                current_limit_sense_trip150, current_limit_sense_trip, undervoltage_trip,
                overvoltage_trip_rel, overvoltage_trip_fixed}),
    .sync_o   ({en_s, hs_s, csp_s, i150_s, current_limit_sense_s, uv_s, ovr_s, ovf_s})
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  rsfs_state_t      st_q, st_d;
  logic [CNT_W-1:0] tmr_q, step_q, lat_q;
  logic [REF_W-1:0] ref_q, ref_d, tgt_q;
  logic [NRAIL-1:0] off_q, flt_q, flt_d;
  logic [NPH-1:0]   live_q;
  logic [2*NPH-1:0] pwm_d;
  logic             pulse_d;
  logic             started_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire              active   = (st_q == S_RAMP) || (st_q == S_RUN);
  wire [NRAIL-1:0]  rail_on  = ~off_q & ~flt_q;
  wire              step_hit = (step_q == STEP_LAST);
  wire              sense_dn = (tmr_q == SENSE_LAST);
  // Fixed threshold while ramping keeps a pre-charged output from tripping
  wire [NRAIL-1:0]  ov_sel   = (st_q == S_RAMP) ? ovf_s : ovr_s;
  wire              ov_any   = active && |(rail_on & ov_sel);
  wire              uv_any   = |(rail_on & uv_s);
  wire              lat_hit  = (lat_q == LATCH_LAST);
  wire              main_ocp = active && rail_on[MAIN_RAIL] && current_limit_sense_s[MAIN_RAIL];
  wire              ref_up   = step_hit && (ref_q < tgt_q);
  wire              ref_dn   = step_hit && (ref_q > tgt_q);

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      S_SENSE: if (sense_dn) st_d = S_WAIT;
      S_WAIT:  if (en_s) st_d = S_MID;
      S_MID:   st_d = S_HSHK;
      S_HSHK:  if (hs_s) st_d = S_RAMP;
      S_RAMP:  if (ref_q == tgt_q) st_d = S_RUN;
      S_RUN:   st_d = S_RUN;
      S_OVP:   st_d = S_OVP;
      S_IDLE:  if (!en_s) st_d = S_WAIT;
      default: st_d = S_SENSE;
    endcase
    if (active && !hs_s)
      st_d = S_MID;
    if (ov_any)
      st_d = S_OVP;
    // Enable low ends every state after sensing; this is the toggle
    if (!en_s && (st_q != S_SENSE))
      st_d = S_WAIT;
  end

  // ----------------------------------------
  // Fault latches
  // ----------------------------------------
  always_comb
  begin
    flt_d = flt_q;
    for (int r = 1; r < NRAIL; r++)
      if (active && rail_on[r] && current_limit_sense_s[r])
        flt_d[r] = 1'b1;
    if (main_ocp && (i150_s || lat_hit))
      flt_d[MAIN_RAIL] = 1'b1;
    if (st_q == S_WAIT)
      flt_d = '0;
  end

  // ----------------------------------------
  // Reference ramp
  // ----------------------------------------
  always_comb
  begin
    ref_d   = ref_q;
    pulse_d = 1'b0;
    unique case (st_q)
      S_RAMP:  if (ref_up) ref_d = ref_q + 1'b1;
      S_RUN:
      begin
        if (ref_up)
        begin
          ref_d   = ref_q + 1'b1;
          pulse_d = 1'b1;
        end
        else if (ref_dn)
          ref_d = ref_q - 1'b1;
      end
      S_OVP:   if (step_hit && (ref_q != '0)) ref_d = ref_q - 1'b1;
      default: ref_d = '0;
    endcase
    if (st_d == S_MID || st_d == S_WAIT)
      ref_d = '0;
  end

  // ----------------------------------------
  // Phase drive codes
  // ----------------------------------------
  always_comb
  begin
    for (int p = 0; p < NPH; p++)
    begin
      // Open only before the first start; a later disable parks every phase at mid
      if (st_q == S_SENSE || (st_q == S_WAIT && !en_s && !started_q))
        pwm_d[2*p +: 2] = PWM_OPEN;
      else if (st_q == S_OVP)
        pwm_d[2*p +: 2] = PWM_LOW;
      else if (!active || !rail_on[ph_rail(p)])
        pwm_d[2*p +: 2] = PWM_MID;
      else if (!live_q[p] && !pwm_request[p])
        pwm_d[2*p +: 2] = PWM_MID;
      else
        pwm_d[2*p +: 2] = pwm_request[p] ? PWM_HIGH : PWM_LOW;
    end
  end

  // ----------------------------------------
  // Sequencer and timers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q   <= S_SENSE;
      tmr_q  <= '0;
      step_q <= '0;
      lat_q  <= '0;
    end
    else
    begin
      st_q   <= st_d;
      tmr_q  <= (st_q == S_SENSE) ? tmr_q + 1'b1 : '0;
      step_q <= (step_hit || st_d != st_q) ? '0 : step_q + 1'b1;
      // Counter restarts whenever the trip clears, so only persistence counts
      lat_q  <= (main_ocp && !lat_hit) ? lat_q + 1'b1 : '0;
    end
  end

  // ----------------------------------------
  // Configuration, target and faults
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      off_q  <= '0;
      flt_q  <= '0;
      tgt_q  <= '0;
      ref_q  <= '0;
      live_q <= '0;
      started_q <= 1'b0;
    end
    else
    begin
      if (st_q == S_SENSE && sense_dn)
        off_q <= {csp_s, 1'b0};
      if (st_q == S_SENSE || st_q == S_WAIT)
        tgt_q <= boot_code;
      else if (dynamic_voltage_change_load && st_q == S_RUN)
        tgt_q <= dynamic_voltage_change_code;
      flt_q  <= flt_d;
      ref_q  <= ref_d;
      live_q <= active ? (live_q | pwm_request) : '0;
      // Remembers a start since power-up; live_q alone clears too early
      if (st_q == S_MID)
        started_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_code                   <= '0;
      test_current_en            <= 1'b0;
      driver_enable_handshake_o  <= 1'b0;
      driver_enable_handshake_oe <= 1'b1;
      negative_sense_input_pulse <= 1'b0;
      regulator_ready_flag       <= 1'b0;
      rail_fault                 <= '0;
      rail_disabled              <= '0;
    end
    else
    begin
      pwm_code                   <= pwm_d;
      test_current_en            <= (st_q == S_SENSE);
      // Released (pulled high) only once PWM is at mid; low pulled otherwise
      driver_enable_handshake_oe <= !(st_q == S_HSHK || active);
      negative_sense_input_pulse <= pulse_d;
      regulator_ready_flag       <= (st_q == S_RUN) && !uv_any && !ov_any;
      rail_fault                 <= flt_q;
      rail_disabled              <= off_q;
    end
  end
  assign ref_code = ref_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_sense_open: assert property (
    st_q == S_SENSE |=> (pwm_code == '0) && test_current_en)
    else $error("PWM not open during sensing");
  chk_hshk_after_mid: assert property (
    $fell(driver_enable_handshake_oe) |-> $past(st_q, 2) == S_MID)
    else $error("Handshake released before mid state");
  chk_ref_step: assert property (
    $past(st_q) == S_RAMP && $changed(ref_q) && st_q != S_MID && st_q != S_WAIT
    |-> ref_q == $past(ref_q) + 1'b1)
    else $error("Ramp step not one code");
  chk_sp_latch: assert property (
    active && rail_on[1] && current_limit_sense_s[1] && en_s |=> flt_q[1] ##1 rail_fault[1])
    else $error("Single-phase limit not latched");
  chk_ocp_150: assert property (
    main_ocp && i150_s && en_s |=> flt_q[MAIN_RAIL])
    else $error("150 percent trip not immediate");
  chk_ocp_delay: assert property (
    $rose(main_ocp) && !i150_s && !flt_q[MAIN_RAIL] |=> !flt_q[MAIN_RAIL])
    else $error("Two-phase latch without delay");
  chk_uv_ready: assert property (
    uv_any |=> !regulator_ready_flag)
    else $error("Ready high during undervoltage");
  chk_ovp_drive: assert property (
    st_q == S_OVP |=> pwm_code == {NPH{PWM_LOW}})
    else $error("OVERVOLTAGE_TRIP drive not all low side");
  chk_ovp_hold: assert property (
    st_q == S_OVP && en_s |=> st_q == S_OVP)
    else $error("OVERVOLTAGE_TRIP state left while enabled");
  chk_disabled_mid: assert property (
    st_q == S_WAIT && started_q |=> pwm_code == {NPH{PWM_MID}})
    else $error("Disabled controller PWM not mid");
  chk_dvc_pulse: assert property (
    negative_sense_input_pulse |-> $past(st_q) == S_RUN && ref_q == $past(ref_q) + 1'b1)
    else $error("Pulse without upward step");

  cov_run:   cover property (st_q == S_RAMP ##1 st_q == S_RUN);
  cov_ovp:   cover property (st_q == S_OVP);
  cov_pulse: cover property (negative_sense_input_pulse);
  cov_ocp:   cover property ($rose(flt_q[MAIN_RAIL]));

endmodule

// File: tb/rsfs_drv_model.sv
// Behavioural gate driver on the shared open-drain driver enable line.
// Assumes a pull-up on the line; the bench raises uvlo to mimic a low driver supply.
module rsfs_drv_model #(
  parameter int MIN_HOLD = 40
) (
  input  wire logic core_clk,
  input  wire logic uvlo,
  input  wire logic dev_pull,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;

  int hold_cnt = 0;

  // Low supply pulls the line and keeps it low for a minimum time
  always @(posedge core_clk)
  begin
    if (uvlo)
      hold_cnt <= MIN_HOLD;
    else if (hold_cnt > 0)
      hold_cnt <= hold_cnt - 1;
  end

  // Wired low with pull-up: either party may hold it, nobody drives it high
  assign line = !(dev_pull || hold_cnt > 0);
endmodule

// File: tb/rsfs_seq_test.sv
// Self-checking bench for the start-up and fault sequencer.
// Assumes short counts: latch 20, step 4, sensing 8 cycles; rail 2 strapped off.
module rsfs_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rsfs_pkg::*;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int         LATCH = 20;
  localparam int         STEP  = 4;
  localparam logic [7:0] BOOT  = 8'h06;
  logic       core_clk   = 1'b0;
  logic       arst_n     = 1'b0;
  logic       enable_pin = 1'b0;
  logic       uvlo       = 1'b0;
  logic       hs_line;
  logic       hs_o;
  logic       hs_oe;
  logic [2:0] cl_trip    = 3'h0;
  logic       cl_trip150 = 1'b0;
  logic [2:0] uv_trip    = 3'h0;
  logic [2:0] ov_rel     = 3'h0;
  logic [2:0] ov_fix     = 3'h0;
  logic [3:0] pwm_req    = 4'h0;
  logic [7:0] dv_code    = 8'h00;
  logic       dv_load    = 1'b0;
  logic [7:0] pwm_code;
  logic [7:0] ref_code;
  logic       tcur;
  logic       nsp;
  logic       rdy;
  logic [2:0] fault;
  logic [2:0] disabled;
  int         bad_count  = 0;
  int         n_compared = 0;
  int         cycles     = 0;

  rsfs_drv_model drv (.core_clk(core_clk), .uvlo(uvlo), .dev_pull(hs_oe && !hs_o),
                      .line(hs_line));

  rsfs_seq #(.LATCH_CYCLES(LATCH), .STEP_CYCLES(STEP), .SENSE_CYCLES(8)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .enable_pin(enable_pin),
    .driver_enable_handshake_i(hs_line), .driver_enable_handshake_o(hs_o),
    .driver_enable_handshake_oe(hs_oe), .current_sense_positive_high(2'h2),
    .current_limit_sense_trip(cl_trip), .current_limit_sense_trip150(cl_trip150),
    .undervoltage_trip(uv_trip), .overvoltage_trip_rel(ov_rel),
    .overvoltage_trip_fixed(ov_fix), .pwm_request(pwm_req), .boot_code(BOOT),
    .dynamic_voltage_change_code(dv_code), .dynamic_voltage_change_load(dv_load),
    .pwm_code(pwm_code), .test_current_en(tcur), .ref_code(ref_code),
    .negative_sense_input_pulse(nsp), .regulator_ready_flag(rdy),
    .rail_fault(fault), .rail_disabled(disabled));

  // Clock and hang guard; ceiling is over ten times the at most 1817 cycles used
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Enable toggle, optional driver low-supply hold, then wait for ready
  task automatic restart(input bit uv);
    int i;
    enable_pin = 1'b0;
    tick(5);
    check8({5'h0, fault}, 8'h00, "faults after toggle");
    check8(pwm_code, 8'h55, "mid while disabled");
    uvlo = uv;
    tick(2);
    uvlo = 1'b0;
    enable_pin = 1'b1;
    if (uv)
    begin
      tick(20);
      check8(ref_code, 8'h00, "ref while deferred");
      check8(pwm_code, 8'h55, "mid while deferred");
    end
    for (i = 0; i < 300 && rdy !== 1'b1; i++)
      tick(1);
    check8({7'h0, rdy}, 8'h01, "ready after start");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_sense();
    tick(3);
    check8({7'h0, tcur}, 8'h01, "test current");
    check8(pwm_code, 8'h00, "pwm open");
    check8({6'h0, hs_oe, hs_o}, 8'h02, "line held in sensing");
    tick(12);
    check8({5'h0, disabled}, 8'h04, "strapped rail");
    check8(pwm_code, 8'h00, "open until enabled");
  endtask

  task automatic t_start();
    int i;
    int n;
    enable_pin = 1'b1;
    for (i = 0; i < 30 && hs_oe !== 1'b0; i++)
      tick(1);
    check8({6'h0, hs_oe, hs_o}, 8'h00, "handshake released");
    check8(pwm_code, 8'h55, "mid before handshake");
    for (i = 0; i < 50 && ref_code !== 8'h01; i++)
      tick(1);
    for (n = 0; n < 50 && ref_code === 8'h01; n++)
      tick(1);
    check8(8'(n), 8'(STEP), "step spacing");
    check8(pwm_code, 8'h55, "mid before first pulse");
    pwm_req = 4'h1;
    tick(4);
    check8(pwm_code, 8'h57, "phase 0 switching");
    pwm_req = 4'h0;
    tick(4);
    check8(pwm_code, 8'h56, "phase 0 low");
    for (i = 0; i < 100 && rdy !== 1'b1; i++)
      tick(1);
    check8(ref_code, BOOT, "ramp target");
  endtask

  task automatic t_dynamic_voltage_change();
    int i;
    int n;
    dv_code = BOOT + 8'h03;
    dv_load = 1'b1;
    tick(1);
    dv_load = 1'b0;
    n = 0;
    for (i = 0; i < 40; i++)
    begin
      tick(1);
      if (nsp === 1'b1)
        n++;
    end
    check8(8'(n), 8'h03, "pulses per up step");
    check8(ref_code, BOOT + 8'h03, "new target");
  endtask

  task automatic t_ocp();
    // Phase 2 asks for high, so only the fault can park it at mid
    pwm_req = 4'h4;
    cl_trip = 3'h2;
    tick(4);
    check8({5'h0, fault}, 8'h02, "single rail latch");
    check8({6'h0, pwm_code[5:4]}, 8'h01, "faulted rail mid");
    cl_trip = 3'h0;
    pwm_req = 4'h0;
    tick(30);
    check8({5'h0, fault}, 8'h02, "fault held");
    restart(1'b0);
    cl_trip = 3'h1;
    tick(LATCH - 6);
    cl_trip = 3'h0;
    tick(5);
    check8({5'h0, fault}, 8'h00, "short overcurrent");
    cl_trip = 3'h1;
    tick(LATCH + 5);
    check8({5'h0, fault}, 8'h01, "persistent overcurrent");
    cl_trip = 3'h0;
    restart(1'b0);
    // A current at 150 percent trips the plain limit comparator as well
    cl_trip = 3'h1;
    cl_trip150 = 1'b1;
    tick(4);
    check8({5'h0, fault}, 8'h01, "150 percent trip");
    cl_trip = 3'h0;
    cl_trip150 = 1'b0;
  endtask

  task automatic t_volt();
    int i;
    uv_trip = 3'h2;
    tick(4);
    check8({7'h0, rdy}, 8'h00, "undervoltage");
    uv_trip = 3'h0;
    restart(1'b0);
    ov_rel = 3'h1;
    tick(4);
    check8({7'h0, rdy}, 8'h00, "overvoltage ready");
    check8(pwm_code, 8'haa, "all low sides on");
    ov_rel = 3'h0;
    for (i = 0; i < 100 && ref_code !== 8'h00; i++)
      tick(1);
    check8(ref_code, 8'h00, "ref ramped down");
    tick(20);
    check8(pwm_code, 8'haa, "protection held");
    enable_pin = 1'b0;
    tick(5);
    check8(pwm_code, 8'h55, "mid after protection");
    enable_pin = 1'b1;
    for (i = 0; i < 30 && hs_oe !== 1'b0; i++)
      tick(1);
    tick(4);
    ov_rel = 3'h1;
    tick(6);
    check8(pwm_code, 8'h55, "relative ignored in ramp");
    ov_rel = 3'h0;
    ov_fix = 3'h1;
    tick(4);
    check8(pwm_code, 8'haa, "fixed threshold in ramp");
    ov_fix = 3'h0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    tick(16);
    arst_n = 1'b1;
    t_sense();
    t_start();
    t_dynamic_voltage_change();
    t_ocp();
    restart(1'b1);
    t_volt();
    conclude();
  end
endmodule
